// ### rtl/supply_monitor_status_flags.sv
// Supply monitor status flag bank with read-to-clear serial access.
// What this block does
// R1 - Detected fault sets flag until read
// R2 - Read clears flags whose condition ended
// R3 - Host rereads to confirm flag cleared
// R4 - Flags zero after power-on reset or nrst
// R5 - Undervoltage register bit layout, reserved zero
// R6 - Overvoltage register bit layout, reserved zero
// R7 - Input overvoltage mirrors off-state latched bit
// R8 - External monitor register layout, reserved zero
// R9 - Disabled external monitor cannot set flags
// R10 - Each register has own read command
// R11 - Monitor enables survive device reset state
// R12 - Set wins over read clear
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_status_flags (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic power_on_reset_n,
  input wire logic input_supply_low,
  input wire logic internal_regulator_low,
  input wire logic step_up_low,
  input wire logic second_stepdown_low,
  input wire logic first_stepdown_low,
  input wire logic io_supply_high,
  input wire logic input_supply_high,
  input wire logic internal_regulator_high,
  input wire logic step_up_high,
  input wire logic second_stepdown_high,
  input wire logic first_stepdown_high,
  input wire logic ext_sense_one_high,
  input wire logic ext_sense_one_low,
  input wire logic ext_sense_two_high,
  input wire logic ext_sense_two_low,
  input wire logic ext_sense_one_enable,
  input wire logic ext_sense_two_enable,
  input wire logic read_valid,
  input wire supply_flags_pkg::read_cmd_t read_cmd,
  output logic [7:0] read_data,
  output logic read_data_valid,
  output logic off_state_input_high_flag
);
  import supply_flags_pkg::*;

  // Power-on reset or nrst initialises the flags; the device reset state does not.
  wire logic bank_rst_n = nrst & power_on_reset_n; // R4

  logic [14:0] cond_raw;
  logic [14:0] cond_sync_w;
  logic [7:0] uv_cond;
  logic [7:0] ov_cond;
  logic [7:0] ext_cond;
  logic [7:0] uv_flags;
  logic [7:0] ov_flags;
  logic [7:0] ext_flags;
  logic ena_one_s1_reg;
  logic ena_one_reg;
  logic ena_two_s1_reg;
  logic ena_two_reg;
  logic [7:0] read_data_next;

  assign cond_raw = {ext_sense_two_high, ext_sense_two_low, ext_sense_one_high,
                     ext_sense_one_low, io_supply_high, input_supply_high,
                     internal_regulator_high, step_up_high, second_stepdown_high,
                     first_stepdown_high, input_supply_low, internal_regulator_low,
                     step_up_low, second_stepdown_low, first_stepdown_low};
  // The analog comparators are asynchronous to the logic clock.
  cond_sync #(.WIDTH(15)) u_cond_sync (
    .sys_clk(sys_clk),
    .nrst(bank_rst_n),
    .async_in(cond_raw),
    .sync_out(cond_sync_w)
  );

  // Enables are synchronised too; kept in the always-on domain so they persist. R11
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ena_one_s1_reg <= 1'b0;
      ena_one_reg <= 1'b0;
      ena_two_s1_reg <= 1'b0;
      ena_two_reg <= 1'b0;
    end else begin
      ena_one_s1_reg <= ext_sense_one_enable;
      ena_one_reg <= ena_one_s1_reg;
      ena_two_s1_reg <= ext_sense_two_enable;
      ena_two_reg <= ena_two_s1_reg;
    end
  end

  always_comb begin
    uv_cond = 8'h00;
    uv_cond[INPUT_SUPPLY_LOW_BIT] = cond_sync_w[4]; // R5
    uv_cond[INTERNAL_REGULATOR_LOW_BIT] = cond_sync_w[3];
    uv_cond[STEP_UP_LOW_BIT] = cond_sync_w[2];
    uv_cond[SECOND_STEPDOWN_LOW_BIT] = cond_sync_w[1];
    uv_cond[FIRST_STEPDOWN_LOW_BIT] = cond_sync_w[0];
  end

  always_comb begin
    ov_cond = 8'h00;
    ov_cond[IO_SUPPLY_HIGH_BIT] = cond_sync_w[10]; // R6
    ov_cond[INPUT_SUPPLY_HIGH_BIT] = cond_sync_w[9];
    ov_cond[INTERNAL_REGULATOR_HIGH_BIT] = cond_sync_w[8];
    ov_cond[STEP_UP_HIGH_BIT] = cond_sync_w[7];
    ov_cond[SECOND_STEPDOWN_HIGH_BIT] = cond_sync_w[6];
    ov_cond[FIRST_STEPDOWN_HIGH_BIT] = cond_sync_w[5];
  end

  always_comb begin
    ext_cond = 8'h00;
    ext_cond[EXT_SENSE_TWO_HIGH_BIT] = cond_sync_w[14] & ena_two_reg; // R8 R9
    ext_cond[EXT_SENSE_TWO_LOW_BIT] = cond_sync_w[13] & ena_two_reg; // R9
    ext_cond[EXT_SENSE_ONE_HIGH_BIT] = cond_sync_w[12] & ena_one_reg; // R9
    ext_cond[EXT_SENSE_ONE_LOW_BIT] = cond_sync_w[11] & ena_one_reg; // R9
  end

  wire logic read_uv = read_valid && (read_cmd == READ_UNDERVOLTAGE_FLAGS_CMD); // R10
  wire logic read_ov = read_valid && (read_cmd == READ_OVERVOLTAGE_FLAGS_CMD); // R10
  wire logic read_ext = read_valid && (read_cmd == READ_EXTERNAL_FLAGS_CMD); // R10

  // Each register latches its faults and clears on its own read. R1 R2 R12
  sticky_flag_reg #(.WIDTH(8), .IMPL_MASK(UNDERVOLTAGE_IMPL_MASK)) u_uv_flags (
    .sys_clk(sys_clk),
    .nrst(bank_rst_n),
    .condition(uv_cond),
    .read_strobe(read_uv),
    .flags(uv_flags)
  );

  sticky_flag_reg #(.WIDTH(8), .IMPL_MASK(OVERVOLTAGE_IMPL_MASK)) u_ov_flags (
    .sys_clk(sys_clk),
    .nrst(bank_rst_n),
    .condition(ov_cond),
    .read_strobe(read_ov),
    .flags(ov_flags)
  );

  sticky_flag_reg #(.WIDTH(8), .IMPL_MASK(EXTERNAL_IMPL_MASK)) u_ext_flags (
    .sys_clk(sys_clk),
    .nrst(bank_rst_n),
    .condition(ext_cond),
    .read_strobe(read_ext),
    .flags(ext_flags)
  );

  // The snapshot returned is taken before the clear; the host must read again. R3
  assign read_data_next = read_uv ? (uv_flags & UNDERVOLTAGE_IMPL_MASK) :
                          read_ov ? (ov_flags & OVERVOLTAGE_IMPL_MASK) :
                          read_ext ? (ext_flags & EXTERNAL_IMPL_MASK) : 8'h00;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      read_data <= FLAGS_RESET;
      read_data_valid <= 1'b0;
    end else begin
      read_data <= read_data_next;
      read_data_valid <= read_uv | read_ov | read_ext;
    end
  end

  // The off-state latched copy is the very same flip-flop, so they cannot disagree.
  assign off_state_input_high_flag = ov_flags[INPUT_SUPPLY_HIGH_BIT]; // R7

endmodule // supply_monitor_status_flags
`default_nettype wire

// ### rtl/supply_flags_pkg.sv
// Shared constants for the supply monitor status flag bank.
package supply_flags_pkg;

  localparam int FLAG_WIDTH = 8;

  // Serial read command selectors, one per status register.
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    READ_UNDERVOLTAGE_FLAGS_CMD = 2'h1,
    READ_OVERVOLTAGE_FLAGS_CMD = 2'h2,
    READ_EXTERNAL_FLAGS_CMD = 2'h3
  } read_cmd_t;

  // Undervoltage register layout.
  localparam int INPUT_SUPPLY_LOW_BIT = 6;
  localparam int INTERNAL_REGULATOR_LOW_BIT = 4;
  localparam int STEP_UP_LOW_BIT = 3;
  localparam int SECOND_STEPDOWN_LOW_BIT = 1;
  localparam int FIRST_STEPDOWN_LOW_BIT = 0;
  localparam logic [7:0] UNDERVOLTAGE_IMPL_MASK = 8'h5B;

  // Overvoltage register layout.
  localparam int IO_SUPPLY_HIGH_BIT = 7;
  localparam int INPUT_SUPPLY_HIGH_BIT = 6;
  localparam int INTERNAL_REGULATOR_HIGH_BIT = 4;
  localparam int STEP_UP_HIGH_BIT = 3;
  localparam int SECOND_STEPDOWN_HIGH_BIT = 1;
  localparam int FIRST_STEPDOWN_HIGH_BIT = 0;
  localparam logic [7:0] OVERVOLTAGE_IMPL_MASK = 8'hDB;

  // External monitor register layout.
  localparam int EXT_SENSE_TWO_HIGH_BIT = 5;
  localparam int EXT_SENSE_TWO_LOW_BIT = 4;
  localparam int EXT_SENSE_ONE_HIGH_BIT = 1;
  localparam int EXT_SENSE_ONE_LOW_BIT = 0;
  localparam logic [7:0] EXTERNAL_IMPL_MASK = 8'h33;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

endpackage : supply_flags_pkg

// ### rtl/cond_sync.sv
// Two-stage synchroniser for asynchronous condition levels.
`timescale 1ns/1ps
`default_nettype none
module cond_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage_one_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_one_reg <= async_in;
      sync_out <= stage_one_reg;
    end
  end
endmodule // cond_sync
`default_nettype wire

// ### rtl/sticky_flag_reg.sv
// One read-clear sticky flag register with set priority.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] condition,
  input wire logic read_strobe,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_next;
  wire logic [WIDTH-1:0] cond_live = condition & IMPL_MASK;

  // Read clears only flags whose condition has gone; a live condition always sets.
  assign flags_next = read_strobe ? cond_live : (flags | cond_live);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= '0;
    end else begin
      flags <= flags_next;
    end
  end
endmodule // sticky_flag_reg
`default_nettype wire

// ### bench/flags_chk_properties.sv
// Port assertions for the supply monitor status flag bank.
`timescale 1ns/1ps
`default_nettype none
module flags_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic power_on_reset_n,
  input wire logic input_supply_high,
  input wire logic read_valid,
  input wire supply_flags_pkg::read_cmd_t read_cmd,
  input wire logic [7:0] read_data,
  input wire logic read_data_valid,
  input wire logic off_state_input_high_flag
);
  import supply_flags_pkg::*;
  logic [2:0] por_hist;
  wire rd = read_valid && read_cmd != CMD_NONE;
  wire rd_ov = read_valid && read_cmd == READ_OVERVOLTAGE_FLAGS_CMD;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst || !power_on_reset_n);
  // A power-on pulse wipes flags mid-pipeline, so the latency check waits for three clean edges.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) por_hist <= 3'h0;
    else por_hist <= {por_hist[1:0], power_on_reset_n};
  end
  a_read_ack: assert property (rd |=> read_data_valid) else $error("read not answered");
  a_no_cmd: assert property (!rd |=> !read_data_valid) else $error("answer without read");
  a_uv_spare:
    assert property (read_data_valid && $past(read_cmd) == READ_UNDERVOLTAGE_FLAGS_CMD
      |-> (read_data & 8'hA4) == 8'h00) else $error("spare bit set");
  a_ext_spare:
    assert property (read_data_valid && $past(read_cmd) == READ_EXTERNAL_FLAGS_CMD
      |-> (read_data & 8'hCC) == 8'h00) else $error("spare bit set");
  a_ov_mirror:
    assert property (read_data_valid && $past(read_cmd) == READ_OVERVOLTAGE_FLAGS_CMD
      |-> read_data[6] == $past(off_state_input_high_flag) && (read_data & 8'h24) == 8'h00)
      else $error("overvoltage read wrong");
  a_por_clear: assert property (disable iff (!nrst) !power_on_reset_n |=>
    !off_state_input_high_flag) else $error("flag kept over power-on");
  a_sticky_hold: assert property (off_state_input_high_flag && !rd_ov |=>
    off_state_input_high_flag) else $error("flag dropped without read");
  a_set_latency: assert property (&por_hist && $past(input_supply_high, 3) |->
    off_state_input_high_flag) else $error("fault not latched");
endmodule // flags_chk
bind supply_monitor_status_flags flags_chk u_flags_chk (.sys_clk, .nrst, .power_on_reset_n,
  .input_supply_high, .read_valid, .read_cmd, .read_data, .read_data_valid,
  .off_state_input_high_flag);
`default_nettype wire

// ### bench/spi_host_model.sv
// Host model issuing serial status reads.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic sys_clk,
  output logic read_valid,
  output supply_flags_pkg::read_cmd_t read_cmd,
  input wire logic [7:0] read_data,
  input wire logic read_data_valid
);
  import supply_flags_pkg::*;
  initial begin
    read_valid = 1'b0;
    read_cmd = CMD_NONE;
  end
  // Only read commands exist; a missing answer returns unknowns so the caller cannot match.
  task automatic read(input read_cmd_t c, output logic [7:0] d);
    @(negedge sys_clk);
    read_valid = 1'b1;
    read_cmd = c;
    @(negedge sys_clk);
    d = (read_data_valid === 1'b1) ? read_data : 8'hXX;
    read_valid = 1'b0;
    read_cmd = CMD_NONE;
  endtask
endmodule // spi_host_model
`default_nettype wire

// ### bench/test_supply_monitor_status_flags.sv
// Self-checking bench for the supply monitor status flag bank.
`timescale 1ns/1ps
`default_nettype none
module test_supply_monitor_status_flags;
  import supply_flags_pkg::*;
  localparam read_cmd_t UVC = READ_UNDERVOLTAGE_FLAGS_CMD;
  localparam read_cmd_t OVC = READ_OVERVOLTAGE_FLAGS_CMD;
  localparam read_cmd_t EXC = READ_EXTERNAL_FLAGS_CMD;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic power_on_reset_n = 1'b1;
  logic [4:0] uv = 5'h00;
  logic [5:0] ov = 6'h00;
  logic [3:0] ext = 4'h0;
  logic [1:0] en = 2'h0;
  logic read_valid;
  read_cmd_t read_cmd;
  logic [7:0] read_data;
  logic read_data_valid;
  logic off_flag;
  int num_errors = 0;
  int checked = 0;
  always #10 sys_clk = ~sys_clk;
  supply_monitor_status_flags u_supply_monitor_status_flags (.sys_clk, .nrst, .power_on_reset_n,
    .input_supply_low(uv[4]), .internal_regulator_low(uv[3]), .step_up_low(uv[2]),
    .second_stepdown_low(uv[1]), .first_stepdown_low(uv[0]), .io_supply_high(ov[5]),
    .input_supply_high(ov[4]), .internal_regulator_high(ov[3]), .step_up_high(ov[2]),
    .second_stepdown_high(ov[1]), .first_stepdown_high(ov[0]), .ext_sense_two_high(ext[3]),
    .ext_sense_two_low(ext[2]), .ext_sense_one_high(ext[1]), .ext_sense_one_low(ext[0]),
    .ext_sense_two_enable(en[1]), .ext_sense_one_enable(en[0]), .read_valid, .read_cmd,
    .read_data, .read_data_valid, .off_state_input_high_flag(off_flag));
  spi_host_model u_spi_host_model (.sys_clk, .read_valid, .read_cmd, .read_data, .read_data_valid);
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input read_cmd_t c, input logic [7:0] exp);
    logic [7:0] d;
    u_spi_host_model.read(c, d);
    chk(exp, d);
  endtask
  // Conditions pass two synchroniser stages before the flag, so four edges cover the latency.
  task automatic settle;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic t_reset;
    rd(UVC, 8'h00);
    rd(OVC, 8'h00);
    rd(EXC, 8'h00);
  endtask
  task automatic t_uv;
    uv = 5'h1F;
    settle;
    uv = 5'h00;
    settle;
    rd(UVC, 8'h5B);
    rd(UVC, 8'h00);
  endtask
  task automatic t_ov;
    ov = 6'h3F;
    settle;
    rd(OVC, 8'hDB);
    rd(OVC, 8'hDB);
    chk(8'h01, {7'h00, off_flag});
    ov = 6'h00;
    settle;
    rd(OVC, 8'hDB);
    rd(OVC, 8'h00);
    chk(8'h00, {7'h00, off_flag});
  endtask
  task automatic t_ext;
    ext = 4'hF;
    settle;
    rd(EXC, 8'h00);
    en = 2'h1;
    settle;
    rd(EXC, 8'h03);
    en = 2'h3;
    settle;
    ext = 4'h0;
    settle;
    rd(EXC, 8'h33);
    rd(EXC, 8'h00);
  endtask
  task automatic t_por;
    uv = 5'h1F;
    settle;
    uv = 5'h00;
    settle;
    power_on_reset_n = 1'b0;
    @(negedge sys_clk);
    power_on_reset_n = 1'b1;
    rd(UVC, 8'h00);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    t_reset;
    t_uv;
    t_ov;
    t_ext;
    t_por;
    summarize;
  end
  initial begin
    #20us;
    num_errors++;
    summarize;
  end
endmodule // test_supply_monitor_status_flags
`default_nettype wire
